// *** logic/memory_map_pkg.sv ***
package memory_map_pkg;

  // Address and count widths of the CPU memory bus.
  localparam int ADDR_W = 22;
  localparam int WAIT_W = 5;
  localparam int ZONES = 5;

  // Flash sector boundaries, Sector J first, Sector A last.
  localparam logic [21:0] FLASH_BIG_LO = 22'h3D8000;
  localparam logic [21:0] FLASH_SMALL_LO = 22'h3E8000;
  localparam logic [21:0] FLASH_HI = 22'h3F7FFF;
  localparam logic [21:0] SECTOR_A_LO = 22'h3F6000;
  localparam logic [9:0][21:0] SECTOR_LO = {
    22'h3F6000, 22'h3F4000, 22'h3F0000, 22'h3EC000, 22'h3E8000,
    22'h3E4000, 22'h3E0000, 22'h3DC000, 22'h3DA000, 22'h3D8000};
  localparam logic [3:0] SECTOR_COUNT = 4'hA;

  // Words inside Sector A with a fixed role.
  localparam logic [21:0] SEC_ZERO_LO = 22'h3F7F80;
  localparam logic [21:0] SEC_ZERO_HI = 22'h3F7FF5;
  localparam logic [21:0] ENTRY_LO = 22'h3F7FF6;
  localparam logic [21:0] ENTRY_HI = 22'h3F7FF7;
  localparam logic [21:0] PASSWORD_LO = 22'h3F7FF8;
  localparam logic [21:0] PASSWORD_HI = 22'h3F7FFF;

  // Placement of the remaining blocks.
  localparam logic [21:0] LOW_A_LO = 22'h000000;
  localparam logic [21:0] LOW_A_HI = 22'h0003FF;
  localparam logic [21:0] LOW_B_LO = 22'h000400;
  localparam logic [21:0] LOW_B_HI = 22'h0007FF;
  localparam logic [21:0] PF0_LO = 22'h000800;
  localparam logic [21:0] PF0_HI = 22'h000FFF;
  localparam logic [21:0] ZONE0_LO = 22'h002000;
  localparam logic [21:0] ZONE0_HI = 22'h003FFF;
  localparam logic [21:0] ZONE1_LO = 22'h004000;
  localparam logic [21:0] ZONE1_HI = 22'h005FFF;
  localparam logic [21:0] PF1_LO = 22'h006000;
  localparam logic [21:0] PF1_HI = 22'h006FFF;
  localparam logic [21:0] PF2_LO = 22'h007000;
  localparam logic [21:0] PF2_HI = 22'h007FFF;
  localparam logic [21:0] MID_A_LO = 22'h008000;
  localparam logic [21:0] MID_A_HI = 22'h008FFF;
  localparam logic [21:0] MID_B_LO = 22'h009000;
  localparam logic [21:0] MID_B_HI = 22'h009FFF;
  localparam logic [21:0] ZONE2_LO = 22'h080000;
  localparam logic [21:0] ZONE2_HI = 22'h0FFFFF;
  localparam logic [21:0] ZONE6_LO = 22'h100000;
  localparam logic [21:0] ZONE6_HI = 22'h17FFFF;
  localparam logic [21:0] OTP_LO = 22'h3D7800;
  localparam logic [21:0] OTP_HI = 22'h3D7BFF;
  localparam logic [21:0] HIGH_LO = 22'h3F8000;
  localparam logic [21:0] HIGH_HI = 22'h3F9FFF;
  localparam logic [21:0] BOOT_LO = 22'h3FF000;
  localparam logic [21:0] BOOT_HI = 22'h3FFFFF;
  localparam logic [21:0] ZONE7_LO = 22'h3FC000;
  localparam logic [21:0] ZONE7_HI = 22'h3FFFFF;

  // Fixed wait-state counts.
  localparam logic [4:0] WAIT_ZERO = 5'h00;
  localparam logic [4:0] WAIT_ONE = 5'h01;
  localparam logic [4:0] WAIT_PF_READ = 5'h02;
  localparam logic [4:0] WAIT_PASSWORD = 5'h10;
  localparam logic [4:0] WAIT_ALIGN = 5'h02;

  // Pin synchroniser settle time before the boot pin is captured.
  localparam logic [2:0] CAPTURE_DELAY = 3'h4;

  // Reset values.
  localparam logic RST_PROTECT = 1'b1;
  localparam logic RST_BOOT_MODE = 1'b0;

  // Zone index in the per-zone configuration vectors.
  localparam int Z0 = 0;
  localparam int Z1 = 1;
  localparam int Z2 = 2;
  localparam int Z6 = 3;
  localparam int Z7 = 4;

  // Decoded target of an access.
  typedef enum logic [4:0] {
    REG_NONE = 5'h00,
    REG_LOW_A = 5'h01,
    REG_LOW_B = 5'h02,
    REG_MID_A = 5'h03,
    REG_MID_B = 5'h04,
    REG_HIGH = 5'h05,
    REG_PF0 = 5'h06,
    REG_PF1 = 5'h07,
    REG_PF2 = 5'h08,
    REG_OTP = 5'h09,
    REG_FLASH = 5'h0A,
    REG_PASSWORD = 5'h0B,
    REG_BOOT = 5'h0C,
    REG_ZONE0 = 5'h0D,
    REG_ZONE1 = 5'h0E,
    REG_ZONE2 = 5'h0F,
    REG_ZONE6 = 5'h10,
    REG_ZONE7 = 5'h11
  } region_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } access_state_e;

  // One request from the CPU memory bus.
  typedef struct packed {
    logic valid;
    logic write;
    logic program_space;
    logic io_space;
    logic [21:0] addr;
  } bus_req_s;

  // Routing result held for the whole access.
  typedef struct packed {
    region_e region;
    logic [3:0] sector;
    logic decode_error;
  } route_s;

endpackage : memory_map_pkg

// *** logic/pin_sync3.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser for two asynchronous pins. The filtered value only
// moves when the second and third stages agree, so a single metastable
// sample can never reach the decoder.
module pin_sync3 (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out
);

  logic [1:0] stage1; // Read only by stage2.
  logic [1:0] stage2; // Second stage.
  logic [1:0] stage3; // Third stage.

  // Shift the pins through the chain and update on agreement.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= 2'h0;
      stage2 <= 2'h0;
      stage3 <= 2'h0;
      pin_out <= 2'h0;
    end
    else if (clk_en)
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      pin_out <= (stage2 & stage3) | (pin_out & (stage2 ^ stage3));
    end
  end

endmodule : pin_sync3

// *** logic/memory_map_wait_state_decoder.sv ***
`timescale 1ns/1ps
// What this block does
// - Flash sectors at fixed ranges per variant.
// - Two entry words hold a branch.
// - Eight password words, never all zero.
// - Legacy code runs from upper 64K.
// - Five zones share three chip selects.
// - Each zone has its own wait count.
// - Each zone chooses to honour ready.
// - Protected write then read keeps order.
// - Protection programmable, enabled after reset.
// - Boot pin high maps zone 7 high.
// - Boot pin low disables zone 7.
// - Boot pin captured into rewritable mode bit.
// - Mode bit remaps boot ROM, zone 7 only.
// - External interface decodes memory accesses only.
// - Fixed wait counts for on-chip blocks.
// - Flash waits programmable, zero minimum.
// - OTP waits programmable, one minimum.
// - Password words always take sixteen waits.
// - External accesses never below one wait.
module memory_map_wait_state_decoder (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire memory_map_pkg::bus_req_s bus_req,
  input wire logic large_flash,
  input wire logic [3:0] flash_wait,
  input wire logic [3:0] otp_wait,
  input wire logic [memory_map_pkg::ZONES-1:0][3:0] zone_wait,
  input wire logic [memory_map_pkg::ZONES-1:0] zone_ready_en,
  input wire logic protect_write_en,
  input wire logic protect_write_val,
  input wire logic boot_mode_write_en,
  input wire logic boot_mode_write_val,
  input wire logic boot_mode_select_pin,
  input wire logic ext_ready,
  output logic bus_ready,
  output logic busy,
  output memory_map_pkg::route_s route,
  output logic zone01_chip_select_n,
  output logic zone2_chip_select_n,
  output logic zone67_chip_select_n,
  output logic boot_mode_bit,
  output logic protect_enable,
  output logic align_inserted
);
  import memory_map_pkg::*;

  // True when an address lies in an inclusive range.
  function automatic logic in_range(input logic [21:0] a,
                                    input logic [21:0] lo,
                                    input logic [21:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Sector number, 0 for Sector J up to 9 for Sector A.
  function automatic logic [3:0] sector_of(input logic [21:0] a);
    sector_of = 4'h0;
    for (int i = 1; i < 10; i++)
    begin
      if (a >= SECTOR_LO[i])
      begin
        sector_of = 4'(i);
      end
    end
  endfunction : sector_of

  logic [1:0] sync_out; // Filtered pins: bit 1 boot pin, bit 0 ready.
  logic boot_pin_sync; // Synchronised boot mode select pin.
  logic ready_sync; // Synchronised external ready.
  logic capture_pending; // Boot pin not yet captured since reset.
  logic [2:0] capture_count; // Settle counter for the capture.
  access_state_e state; // Access sequencer state.
  access_state_e next_state; // Next sequencer state.
  logic [4:0] wait_count; // Wait states still to spend.
  logic use_ready; // Current access honours external ready.
  logic last_prot_write; // Previous taken access was a protected write.
  logic [21:0] last_addr; // Address of the previous taken access.

  // Both asynchronous pins share one synchroniser.
  pin_sync3 u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin_in({boot_mode_select_pin, ext_ready}),
    .pin_out(sync_out)
  );

  assign boot_pin_sync = sync_out[1];
  assign ready_sync = sync_out[0];

  // Address decode. Peripheral frames refuse program-space cycles only, and no
  // external zone answers an I/O cycle since the interface has no I/O map.
  wire [21:0] a = bus_req.addr;
  wire flash_lo_ok = a >= (large_flash ? FLASH_BIG_LO : FLASH_SMALL_LO);
  wire hit_flash = flash_lo_ok && (a <= FLASH_HI);
  wire hit_password = in_range(a, PASSWORD_LO, PASSWORD_HI);
  wire hit_pf0 = in_range(a, PF0_LO, PF0_HI);
  wire hit_pf1 = in_range(a, PF1_LO, PF1_HI);
  wire hit_pf2 = in_range(a, PF2_LO, PF2_HI);
  wire hit_pf = hit_pf0 || hit_pf1 || hit_pf2;
  wire pf_blocked = bus_req.program_space && hit_pf;
  wire ext_blocked = bus_req.io_space;
  // Only boot ROM and zone 7 look at the mode bit; nothing else moves.
  wire hit_top = in_range(a, BOOT_LO, BOOT_HI);
  wire hit_boot = hit_top && !boot_mode_bit;
  wire hit_zone7 = in_range(a, ZONE7_LO, ZONE7_HI) && boot_mode_bit;

  region_e dec_region; // Region of the offered request.
  always_comb
  begin
    dec_region = REG_NONE;
    if (in_range(a, LOW_A_LO, LOW_A_HI))
      dec_region = REG_LOW_A;
    else if (in_range(a, LOW_B_LO, LOW_B_HI))
      dec_region = REG_LOW_B;
    else if (in_range(a, MID_A_LO, MID_A_HI))
      dec_region = REG_MID_A;
    else if (in_range(a, MID_B_LO, MID_B_HI))
      dec_region = REG_MID_B;
    else if (in_range(a, HIGH_LO, HIGH_HI))
      dec_region = REG_HIGH;
    else if (hit_pf0 && !pf_blocked)
      dec_region = REG_PF0;
    else if (hit_pf1 && !pf_blocked)
      dec_region = REG_PF1;
    else if (hit_pf2 && !pf_blocked)
      dec_region = REG_PF2;
    else if (in_range(a, OTP_LO, OTP_HI))
      dec_region = REG_OTP;
    else if (hit_flash && hit_password)
      dec_region = REG_PASSWORD;
    else if (hit_flash)
      dec_region = REG_FLASH;
    else if (hit_boot)
      dec_region = REG_BOOT;
    else if (ext_blocked)
      dec_region = REG_NONE;
    else if (hit_zone7)
      dec_region = REG_ZONE7;
    else if (in_range(a, ZONE0_LO, ZONE0_HI))
      dec_region = REG_ZONE0;
    else if (in_range(a, ZONE1_LO, ZONE1_HI))
      dec_region = REG_ZONE1;
    else if (in_range(a, ZONE2_LO, ZONE2_HI))
      dec_region = REG_ZONE2;
    else if (in_range(a, ZONE6_LO, ZONE6_HI))
      dec_region = REG_ZONE6;
  end

  // Zone index of the offered request, valid only for external regions.
  wire is_ext = (dec_region >= REG_ZONE0) && (dec_region <= REG_ZONE7);
  wire [2:0] zone_idx = is_ext ? 3'(dec_region - REG_ZONE0) : 3'h0;
  wire [3:0] zone_cfg = zone_wait[zone_idx];
  wire [4:0] zone_waits = (zone_cfg == 4'h0) ? WAIT_ONE : {1'b0, zone_cfg};
  wire [4:0] otp_waits = (otp_wait == 4'h0) ? WAIT_ONE : {1'b0, otp_wait};

  // Wait count of the offered request before any alignment penalty.
  logic [4:0] base_waits;
  always_comb
  begin
    case (dec_region)
      REG_PF1, REG_PF2:
        base_waits = bus_req.write ? WAIT_ZERO : WAIT_PF_READ;
      REG_OTP:
        base_waits = otp_waits;
      REG_FLASH:
        base_waits = {1'b0, flash_wait};
      REG_PASSWORD:
        base_waits = WAIT_PASSWORD;
      REG_BOOT:
        base_waits = WAIT_ONE;
      REG_ZONE0, REG_ZONE1, REG_ZONE2, REG_ZONE6, REG_ZONE7:
        base_waits = zone_waits;
      default:
        base_waits = WAIT_ZERO;
    endcase
  end

  // Ordering protection: a read that follows a write inside the group at a
  // different word gets extra cycles so the write reaches the bus first.
  wire in_group = (dec_region == REG_PF1) || (dec_region == REG_PF2) ||
                  (dec_region == REG_ZONE1);
  wire need_align = protect_enable && in_group && !bus_req.write &&
                    last_prot_write && (a != last_addr);
  wire [4:0] total_waits = need_align ? 5'(base_waits + WAIT_ALIGN)
                                      : base_waits;
  wire take = (state == ST_IDLE) && bus_req.valid;
  wire wait_over = (wait_count == WAIT_ZERO) && (!use_ready || ready_sync);

  // Sequencer: idle takes a request, wait spends the counted cycles.
  always_comb
  begin
    case (state)
      ST_IDLE:
        next_state = take ? ST_WAIT : ST_IDLE;
      ST_WAIT:
        next_state = wait_over ? ST_IDLE : ST_WAIT;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // Chip selects of the offered request; paired zones share a pin.
  wire cs01 = (dec_region == REG_ZONE0) || (dec_region == REG_ZONE1);
  wire cs2 = dec_region == REG_ZONE2;
  wire cs67 = (dec_region == REG_ZONE6) || (dec_region == REG_ZONE7);

  // Access sequencing, wait counting and held routing outputs.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      wait_count <= WAIT_ZERO;
      use_ready <= 1'b0;
      bus_ready <= 1'b0;
      busy <= 1'b0;
      route <= '{region: REG_NONE, sector: 4'h0, decode_error: 1'b0};
      zone01_chip_select_n <= 1'b1;
      zone2_chip_select_n <= 1'b1;
      zone67_chip_select_n <= 1'b1;
      align_inserted <= 1'b0;
      last_prot_write <= 1'b0;
      last_addr <= 22'h000000;
    end
    else if (clk_en)
    begin
      state <= next_state;
      bus_ready <= (state == ST_WAIT) && wait_over;
      busy <= next_state == ST_WAIT;
      if (take)
      begin
        wait_count <= total_waits;
        use_ready <= is_ext && zone_ready_en[zone_idx];
        route.region <= dec_region;
        route.sector <= hit_flash ? sector_of(a) : 4'h0;
        route.decode_error <= dec_region == REG_NONE;
        zone01_chip_select_n <= !cs01;
        zone2_chip_select_n <= !cs2;
        zone67_chip_select_n <= !cs67;
        align_inserted <= need_align;
        last_prot_write <= in_group && bus_req.write;
        last_addr <= a;
      end
      else if (state == ST_WAIT)
      begin
        if (wait_count != WAIT_ZERO)
        begin
          wait_count <= 5'(wait_count - WAIT_ONE);
        end
        else if (wait_over)
        begin
          // Release the chip selects together with the completion pulse.
          zone01_chip_select_n <= 1'b1;
          zone2_chip_select_n <= 1'b1;
          zone67_chip_select_n <= 1'b1;
        end
        // With ready honoured and low, the count sits at zero and the
        // access stretches for as long as the device asks.
      end
    end
  end

  // Protection enable: set after reset, rewritable by software.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      protect_enable <= RST_PROTECT;
    end
    else if (clk_en && protect_write_en)
    begin
      protect_enable <= protect_write_val;
    end
  end

  // Boot mode bit. The pin is caught once the synchroniser has settled
  // after reset release; a reset value cannot come from the pin itself.
  // A software write in the capture cycle loses, as the strap is the
  // defining value of that moment.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      boot_mode_bit <= RST_BOOT_MODE;
      capture_pending <= 1'b1;
      capture_count <= 3'h0;
    end
    else if (clk_en)
    begin
      if (capture_pending)
      begin
        if (capture_count == CAPTURE_DELAY)
        begin
          boot_mode_bit <= boot_pin_sync;
          capture_pending <= 1'b0;
        end
        else
        begin
          capture_count <= 3'(capture_count + 3'h1);
        end
      end
      else if (boot_mode_write_en)
      begin
        boot_mode_bit <= boot_mode_write_val;
      end
    end
  end

endmodule : memory_map_wait_state_decoder

// *** bench/cpu_bus_master.sv ***
`timescale 1ns/1ps
// CPU bus master model: one request at a time, valid for one cycle only.
module cpu_bus_master (
  input wire logic ref_clk,
  input wire logic bus_ready,
  output memory_map_pkg::bus_req_s bus_req
);
  import memory_map_pkg::*;
  // The bus is idle from time zero.
  initial bus_req = '0;
  // Drive at the falling edge, drop after the take edge, count edges.
  // A count of zero means the answer never came within the bound.
  task automatic access(input bus_req_s r, output int k);
    begin
      k = 0;
      @(negedge ref_clk);
      bus_req = r;
      @(negedge ref_clk);
      // A released bus shows a changed pattern, never the old request.
      bus_req = {1'b0, ~r[24:0]};
      for (int i = 1; i <= 60; i++)
      begin
        @(posedge ref_clk);
        #1;
        if (bus_ready === 1'b1)
        begin
          k = i;
          break;
        end
      end
    end
  endtask : access
endmodule : cpu_bus_master

// *** bench/memory_map_wait_state_decoder_properties.sv ***
`timescale 1ns/1ps
// Port checker for the decoder; all checks run on ref_clk.
module memory_map_wait_state_decoder_properties (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire memory_map_pkg::bus_req_s bus_req,
  input wire logic protect_write_en,
  input wire logic protect_write_val,
  input wire logic bus_ready,
  input wire logic busy,
  input wire memory_map_pkg::route_s route,
  input wire logic zone01_chip_select_n,
  input wire logic zone2_chip_select_n,
  input wire logic zone67_chip_select_n,
  input wire logic boot_mode_bit,
  input wire logic protect_enable
);
  import memory_map_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // A request is taken only while the decoder is idle.
  wire take = clk_en && bus_req.valid && !busy;
  wire [21:0] a = bus_req.addr;
  wire io = bus_req.io_space;
  // Zones 0 to 6 sit in two contiguous stretches of the map.
  wire ext = (a inside {[ZONE0_LO:ZONE1_HI]}) ||
    (a inside {[ZONE2_LO:ZONE6_HI]});
  AST_RDY_IDLE: assert property (bus_ready |-> !busy)
    else $error("ready while busy");
  AST_SRAM_ZERO: assert property (take && a <= LOW_B_HI |->
    ##1 !bus_ready ##1 bus_ready) else $error("sram wait wrong");
  AST_BOOT_ONE: assert property (take && !boot_mode_bit && a >= BOOT_LO
    |-> ##1 !bus_ready ##1 (!bus_ready && route.region == REG_BOOT)
    ##1 bus_ready) else $error("boot rom wait or map wrong");
  AST_PWD_16: assert property (take &&
    (a inside {[PASSWORD_LO:PASSWORD_HI]}) |-> ##17 !bus_ready ##1 bus_ready)
    else $error("password wait wrong");
  AST_Z7_HIGH: assert property (take && boot_mode_bit && a >= ZONE7_LO
    && !io |-> ##2 route.region == REG_ZONE7 && !zone67_chip_select_n)
    else $error("zone 7 not mapped high");
  AST_EXT_MIN: assert property (take && ext && !io |-> ##2 !bus_ready)
    else $error("external access without wait");
  AST_IO_NONE: assert property (take && ext && io |-> ##2
    route.decode_error && zone01_chip_select_n && zone2_chip_select_n)
    else $error("io cycle reached external zone");
  AST_SECTOR_A: assert property (take && a == SECTOR_A_LO |-> ##2
    route.region == REG_FLASH && route.sector == 4'h9)
    else $error("sector a misplaced");
  AST_CS01: assert property (!zone01_chip_select_n |->
    route.region inside {REG_ZONE0, REG_ZONE1}) else $error("cs01 wrong");
  AST_CS2: assert property (!zone2_chip_select_n |->
    route.region == REG_ZONE2) else $error("cs2 wrong");
  AST_CS67: assert property (!zone67_chip_select_n |->
    route.region inside {REG_ZONE6, REG_ZONE7}) else $error("cs67 wrong");
  AST_PROT_HOLD: assert property (!$past(protect_write_en) |->
    $stable(protect_enable)) else $error("protect changed alone");
  AST_PROT_WR: assert property (protect_write_en |=>
    protect_enable == $past(protect_write_val)) else $error("protect lost");
endmodule : memory_map_wait_state_decoder_properties

bind memory_map_wait_state_decoder memory_map_wait_state_decoder_properties
  memory_map_wait_state_decoder_properties_inst (.ref_clk, .reset_n,
  .clk_en, .bus_req, .protect_write_en, .protect_write_val, .bus_ready,
  .busy, .route, .zone01_chip_select_n, .zone2_chip_select_n,
  .zone67_chip_select_n, .boot_mode_bit, .protect_enable);

// *** bench/memory_map_wait_state_decoder_tb_top.sv ***
`timescale 1ns/1ps
// Self-checking bench: directed corners first, then random accesses.
module memory_map_wait_state_decoder_tb_top;
  import memory_map_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic large_flash = 1'b1;
  logic [3:0] flash_wait = 4'h0;
  logic [3:0] otp_wait = 4'h0;
  logic [ZONES-1:0][3:0] zone_wait = '0;
  logic [ZONES-1:0] zone_ready_en = '0;
  logic protect_write_en = 1'b0;
  logic protect_write_val = 1'b0;
  logic boot_mode_write_en = 1'b0;
  logic boot_mode_write_val = 1'b0;
  logic boot_mode_select_pin = 1'b1;
  logic ext_ready = 1'b1;
  bus_req_s bus_req;
  route_s route;
  logic bus_ready, busy, boot_mode_bit, protect_enable, align_inserted;
  logic zone01_chip_select_n, zone2_chip_select_n, zone67_chip_select_n;
  int fail_count = 0;
  int num_checks = 0;
  int seed = 66892;
  int k;
  logic [31:0] rv;
  // Expected mode bit, protect state and the last group write.
  logic mode = 1'b1;
  logic prot = 1'b1;
  logic pw = 1'b0;
  logic [21:0] pa = 22'h000000;
  // Random bases; two of them straddle sector and block boundaries.
  logic [21:0] bases [12] = '{LOW_A_LO, MID_B_LO, PF0_LO, PF1_LO, PF2_LO,
    ZONE0_LO, ZONE1_LO, ZONE2_LO, ZONE6_LO, OTP_LO, 22'h3D9F80, SEC_ZERO_LO};
  always #5 ref_clk = ~ref_clk;
  memory_map_wait_state_decoder memory_map_wait_state_decoder_inst (
    .ref_clk, .reset_n, .clk_en(1'b1), .bus_req, .large_flash, .flash_wait,
    .otp_wait, .zone_wait, .zone_ready_en, .protect_write_en,
    .protect_write_val, .boot_mode_write_en, .boot_mode_write_val,
    .boot_mode_select_pin, .ext_ready, .bus_ready, .busy, .route,
    .zone01_chip_select_n, .zone2_chip_select_n, .zone67_chip_select_n,
    .boot_mode_bit, .protect_enable, .align_inserted);
  cpu_bus_master cpu_bus_master_inst (.ref_clk, .bus_ready, .bus_req);
  // Zone waits below one are lifted to one.
  function automatic int zw(int i);
    return (zone_wait[i] == 4'h0) ? 1 : zone_wait[i];
  endfunction : zw
  // Expected target of an address from the map and the current mode.
  function automatic region_e exp_region(logic [21:0] a, logic p, logic io);
    if (a <= LOW_A_HI) return REG_LOW_A;
    if (a inside {[LOW_B_LO:LOW_B_HI]}) return REG_LOW_B;
    if (a inside {[PF0_LO:PF0_HI]}) return p ? REG_NONE : REG_PF0;
    if (a inside {[ZONE0_LO:ZONE0_HI]}) return io ? REG_NONE : REG_ZONE0;
    if (a inside {[ZONE1_LO:ZONE1_HI]}) return io ? REG_NONE : REG_ZONE1;
    if (a inside {[PF1_LO:PF1_HI]}) return p ? REG_NONE : REG_PF1;
    if (a inside {[PF2_LO:PF2_HI]}) return p ? REG_NONE : REG_PF2;
    if (a inside {[MID_A_LO:MID_A_HI]}) return REG_MID_A;
    if (a inside {[MID_B_LO:MID_B_HI]}) return REG_MID_B;
    if (a inside {[ZONE2_LO:ZONE2_HI]}) return io ? REG_NONE : REG_ZONE2;
    if (a inside {[ZONE6_LO:ZONE6_HI]}) return io ? REG_NONE : REG_ZONE6;
    if (a inside {[OTP_LO:OTP_HI]}) return REG_OTP;
    if (a inside {[PASSWORD_LO:PASSWORD_HI]}) return REG_PASSWORD;
    if (a >= (large_flash ? FLASH_BIG_LO : FLASH_SMALL_LO) && a <= FLASH_HI)
      return REG_FLASH;
    if (a inside {[HIGH_LO:HIGH_HI]}) return REG_HIGH;
    if (mode && a >= ZONE7_LO) return io ? REG_NONE : REG_ZONE7;
    if (!mode && a >= BOOT_LO) return REG_BOOT;
    return REG_NONE;
  endfunction : exp_region
  // Expected wait count of a region before any alignment cycles.
  function automatic int exp_wait(region_e r, logic w);
    case (r)
      REG_PF1, REG_PF2: return w ? 0 : 2;
      REG_BOOT: return 1;
      REG_PASSWORD: return 16;
      REG_FLASH: return flash_wait;
      REG_OTP: return (otp_wait == 4'h0) ? 1 : otp_wait;
      REG_ZONE0: return zw(Z0);
      REG_ZONE1: return zw(Z1);
      REG_ZONE2: return zw(Z2);
      REG_ZONE6: return zw(Z6);
      REG_ZONE7: return zw(Z7);
      default: return 0;
    endcase
  endfunction : exp_wait
  task automatic chk_lat(input int got, input int exp);
    num_checks++;
    if (got != exp)
    begin
      fail_count++;
      $display("MISMATCH %0t latency %0d not %0d", $time, got, exp);
    end
  endtask : chk_lat
  task automatic chk_route(input route_s got, input route_s exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t route %h not %h", $time, got, exp);
    end
  endtask : chk_route
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t flag %b not %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  // One access with latency, route and alignment flag compared against the map.
  task automatic acc(input logic [21:0] a, input logic w, input logic p,
    input logic io);
    route_s e;
    logic al;
    logic grp;
    int n;
    int got;
    begin
      e.region = exp_region(a, p, io);
      e.sector = 4'h0;
      if (e.region inside {REG_FLASH, REG_PASSWORD})
        for (int i = 0; i < 10; i++)
          if (a >= SECTOR_LO[i]) e.sector = 4'(i);
      e.decode_error = (e.region == REG_NONE);
      grp = e.region inside {REG_PF1, REG_PF2, REG_ZONE1};
      al = prot && !w && grp && pw && (a != pa);
      n = exp_wait(e.region, w) + (al ? 3 : 1);
      cpu_bus_master_inst.access('{1'b1, w, p, io, a}, got);
      if (got == 0)
      begin
        fail_count++;
        results();
      end
      chk_lat(got, n);
      chk_route(route, e);
      chk_bit(align_inserted, al);
      pw = w && grp;
      pa = a;
    end
  endtask : acc
  // One-cycle strobe write of the protection setting.
  task automatic set_prot(input logic v);
    @(negedge ref_clk);
    protect_write_en = 1'b1;
    protect_write_val = v;
    @(negedge ref_clk);
    protect_write_en = 1'b0;
    prot = v;
    chk_bit(protect_enable, v);
  endtask : set_prot
  task automatic restart(input logic pin);
    @(negedge ref_clk);
    reset_n = 1'b0;
    boot_mode_select_pin = pin;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    // The pin is captured a few edges after release.
    repeat (6) @(negedge ref_clk);
    mode = pin;
    prot = 1'b1;
    pw = 1'b0;
    chk_bit(boot_mode_bit, pin);
    chk_bit(protect_enable, 1'b1);
  endtask : restart
  initial
  begin
    restart(1'b1);
    acc(22'h3FFFF0, '0, '1, '0);
    acc(HIGH_LO, '0, '1, '0);
    @(negedge ref_clk);
    boot_mode_write_en = 1'b1;
    @(negedge ref_clk);
    boot_mode_write_en = 1'b0;
    mode = 1'b0;
    chk_bit(boot_mode_bit, 1'b0);
    acc(22'h3FFFF0, '0, '1, '0);
    acc(22'h3FD000, '0, '0, '0);
    acc(HIGH_LO, '0, '0, '0);
    acc(SEC_ZERO_LO, '1, '0, '0);
    acc(ENTRY_LO, '0, '1, '0);
    acc(PASSWORD_HI, '0, '0, '0);
    acc(SECTOR_A_LO, '0, '0, '0);
    acc(OTP_LO, '0, '0, '0);
    acc(PF1_LO, '1, '0, '0);
    acc(PF2_LO, '0, '0, '0);
    acc(PF2_LO, '1, '0, '0);
    acc(PF2_LO, '0, '0, '0);
    set_prot(1'b0);
    acc(ZONE1_LO, '1, '0, '0);
    acc(PF1_LO, '0, '0, '0);
    set_prot(1'b1);
    acc(ZONE2_LO, '0, '0, '1);
    acc(PF0_LO, '0, '1, '0);
    // The external device holds ready off to stretch a zone 2 read.
    zone_ready_en[Z2] = 1'b1;
    ext_ready = 1'b0;
    repeat (6) @(negedge ref_clk);
    fork
      cpu_bus_master_inst.access('{1'b1, 1'b0, 1'b0, 1'b0, ZONE2_LO}, k);
      begin
        repeat (10) @(negedge ref_clk);
        chk_bit(zone2_chip_select_n, 1'b0);
        ext_ready = 1'b1;
      end
    join
    chk_bit(k > 9, 1'b1);
    zone_ready_en[Z2] = 1'b0;
    ext_ready = 1'b0;
    repeat (6) @(negedge ref_clk);
    acc(ZONE2_LO, '0, '0, '0);
    ext_ready = 1'b1;
    repeat (6) @(negedge ref_clk);
    repeat (40)
    begin
      @(negedge ref_clk);
      rv = $random(seed);
      zone_wait = rv[19:0];
      flash_wait = rv[23:20];
      otp_wait = rv[27:24];
      large_flash = rv[28];
      if (rv[31:29] == 3'h0) set_prot(rv[0]);
      rv = $random(seed);
      acc(bases[rv[3:0] % 12] + {14'h0, rv[11:4]}, rv[12], rv[13],
        rv[16:14] == 3'h0);
    end
    restart(1'b0);
    acc(22'h3FFFF0, '0, '1, '0);
    results();
  end
endmodule : memory_map_wait_state_decoder_tb_top
